/* include/csm_pkg.sv */
package csm_pkg;
  localparam int CSM_CTL_W = 32;
  // memory controller config bit positions
  localparam int CSM_BIT_CS_TO_4_7 = 11;
  localparam int CSM_BIT_CS_TO_8_11 = 12;
  localparam int CSM_BIT_UNUSED = 13;
  localparam int CSM_BIT_DQM_STROBES = 14;
  localparam int CSM_BIT_DQM_ARB = 15;
  // chip control word status positions
  localparam int CSM_BIT_PCI64_EXT = 9;
  localparam int CSM_BIT_PCI32_EXT = 16;
  // chip select groups
  localparam int CSM_CS_GROUP_W = 4;
  localparam int CSM_NUM_BANKS = 6;
  localparam int CSM_CS_OUT_W = 12;
  localparam logic [CSM_CS_GROUP_W-1:0] CSM_CS_IDLE = 4'hF;
  localparam logic [CSM_CTL_W-1:0] CSM_CTL_ZERO = 32'h0000_0000;
  typedef enum logic [1:0] {CSM_WAIT_PG, CSM_SAMPLE, CSM_HOLD} csm_strap_t;
endpackage

/* rtl/csm_pin_mux.sv */
`timescale 1ns/1ps
`default_nettype none
module csm_pin_mux
  import csm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [CSM_CTL_W-1:0] i_memory_controller_config,
  input wire logic [CSM_CS_OUT_W-1:0] i_mem_chip_select_n,
  input wire logic i_sdram_data_mask_out,
  input wire logic i_row_strobe_second_n,
  input wire logic i_column_strobe_second_n,
  input wire logic i_write_enable_second_n,
  input wire logic i_pci64_arbitration_out,
  input wire logic i_power_good_in,
  input wire logic i_pll_reset,
  input wire logic i_pci32_request_two_n,
  input wire logic i_pci64_request_two_n,
  output logic [CSM_CS_OUT_W-1:0] o_mem_chip_select_n,
  output logic o_row_strobe_second_n,
  output logic o_column_strobe_second_n,
  output logic o_write_enable_second_n,
  output logic o_pci64_arbitration_out,
  output logic o_pci32_arb_enable,
  output logic o_pci64_arb_enable,
  output logic [CSM_CTL_W-1:0] o_chip_control_word
);
  // pin synchronisers, first stage read only by second
  logic pg_s1_r, pg_s2_r, pll_s1_r, pll_s2_r;
  logic r32_s1_r, r32_s2_r, r64_s1_r, r64_s2_r;
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      pg_s1_r <= 1'b0;
      pg_s2_r <= 1'b0;
      pll_s1_r <= 1'b0;
      pll_s2_r <= 1'b0;
      r32_s1_r <= 1'b1;
      r32_s2_r <= 1'b1;
      r64_s1_r <= 1'b1;
      r64_s2_r <= 1'b1;
    end
    else
    begin
      pg_s1_r <= i_power_good_in;
      pg_s2_r <= pg_s1_r;
      pll_s1_r <= i_pll_reset;
      pll_s2_r <= pll_s1_r;
      r32_s1_r <= i_pci32_request_two_n;
      r32_s2_r <= r32_s1_r;
      r64_s1_r <= i_pci64_request_two_n;
      r64_s2_r <= r64_s1_r;
    end
  end

  // strap capture
  csm_strap_t state_r, state_nxt;
  logic ext32_r, ext64_r, ext32_nxt, ext64_nxt;
  wire capture = (state_r == CSM_SAMPLE) && pll_s2_r;
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      CSM_WAIT_PG: if (pg_s2_r) state_nxt = CSM_SAMPLE;
      CSM_SAMPLE: if (!pg_s2_r) state_nxt = CSM_WAIT_PG;
        else if (pll_s2_r) state_nxt = CSM_HOLD;
      CSM_HOLD: if (!pg_s2_r) state_nxt = CSM_WAIT_PG;
    endcase
  end
  assign ext32_nxt = capture ? ~r32_s2_r : ext32_r;
  assign ext64_nxt = capture ? ~r64_s2_r : ext64_r;
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state_r <= CSM_WAIT_PG;
      ext32_r <= 1'b0;
      ext64_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      ext32_r <= ext32_nxt;
      ext64_r <= ext64_nxt;
    end
  end

  // chip select routing; only banks 0-5 exist upstream, cs 12-15 absent
  wire [CSM_CS_GROUP_W-1:0] cs_low = i_mem_chip_select_n[CSM_CS_GROUP_W-1:0];
  wire [CSM_CS_GROUP_W-1:0] cs_g1 = i_mem_chip_select_n[2*CSM_CS_GROUP_W-1:CSM_CS_GROUP_W];
  wire [CSM_CS_GROUP_W-1:0] cs_g2 = i_mem_chip_select_n[CSM_CS_OUT_W-1:2*CSM_CS_GROUP_W];
  wire [CSM_CS_GROUP_W-1:0] pin_g1 = i_memory_controller_config[CSM_BIT_CS_TO_4_7] ? cs_low : cs_g1;
  // group two mirror; bit 13 never decoded
  wire [CSM_CS_GROUP_W-1:0] pin_g2 = i_memory_controller_config[CSM_BIT_CS_TO_8_11] ? cs_low : cs_g2;
  wire dqm_str = i_memory_controller_config[CSM_BIT_DQM_STROBES];
  wire dqm_arb = i_memory_controller_config[CSM_BIT_DQM_ARB];
  wire ras_pin = dqm_str ? i_sdram_data_mask_out : i_row_strobe_second_n;
  wire cas_pin = dqm_str ? i_sdram_data_mask_out : i_column_strobe_second_n;
  wire we_pin = dqm_str ? i_sdram_data_mask_out : i_write_enable_second_n;
  wire arb_pin = dqm_arb ? i_sdram_data_mask_out : i_pci64_arbitration_out;
  logic [CSM_CTL_W-1:0] ccw;
  always_comb
  begin
    ccw = CSM_CTL_ZERO;
    ccw[CSM_BIT_PCI32_EXT] = ext32_r;
    ccw[CSM_BIT_PCI64_EXT] = ext64_r;
  end

  // registered pins add one cycle of latency, outputs stay glitch free
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_mem_chip_select_n <= {CSM_CS_IDLE, CSM_CS_IDLE, CSM_CS_IDLE};
      o_row_strobe_second_n <= 1'b1;
      o_column_strobe_second_n <= 1'b1;
      o_write_enable_second_n <= 1'b1;
      o_pci64_arbitration_out <= 1'b0;
      o_pci32_arb_enable <= 1'b1;
      o_pci64_arb_enable <= 1'b1;
      o_chip_control_word <= CSM_CTL_ZERO;
    end
    else
    begin
      o_mem_chip_select_n <= {pin_g2, pin_g1, cs_low};
      o_row_strobe_second_n <= ras_pin;
      o_column_strobe_second_n <= cas_pin;
      o_write_enable_second_n <= we_pin;
      o_pci64_arbitration_out <= arb_pin;
      o_pci32_arb_enable <= ~ext32_r;
      o_pci64_arb_enable <= ~ext64_r;
      o_chip_control_word <= ccw;
    end
  end

  // output group views, checks compare against last cycle's inputs
  wire [CSM_CS_GROUP_W-1:0] out_g0 = o_mem_chip_select_n[CSM_CS_GROUP_W-1:0];
  wire [CSM_CS_GROUP_W-1:0] out_g1 = o_mem_chip_select_n[2*CSM_CS_GROUP_W-1:CSM_CS_GROUP_W];
  wire [CSM_CS_GROUP_W-1:0] out_g2 = o_mem_chip_select_n[CSM_CS_OUT_W-1:2*CSM_CS_GROUP_W];

  a_cs_group_one: assert property (@(posedge i_clk) disable iff (i_rst)
    i_memory_controller_config[CSM_BIT_CS_TO_4_7] |=> out_g1 == $past(cs_low))
    else $error("cs 4-7 not mirroring cs 0-3");
  a_cs_group_own: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_memory_controller_config[CSM_BIT_CS_TO_4_7] |=> out_g1 == $past(cs_g1))
    else $error("cs 4-7 not on their own pins");
  a_cs_low_pass: assert property (@(posedge i_clk) disable iff (i_rst)
    1'b1 |=> out_g0 == $past(cs_low))
    else $error("cs 0-3 not on their own pins");
  a_cs_group_two: assert property (@(posedge i_clk) disable iff (i_rst)
    i_memory_controller_config[CSM_BIT_CS_TO_8_11] |=> out_g2 == $past(cs_low))
    else $error("cs 8-11 not mirroring cs 0-3");
  a_cs_two_own: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_memory_controller_config[CSM_BIT_CS_TO_8_11] |=> out_g2 == $past(cs_g2))
    else $error("cs 8-11 not on their own pins");
  a_dqm_strobes: assert property (@(posedge i_clk) disable iff (i_rst)
    dqm_str |=> o_write_enable_second_n == $past(i_sdram_data_mask_out)
      && o_row_strobe_second_n == $past(i_sdram_data_mask_out)
      && o_column_strobe_second_n == $past(i_sdram_data_mask_out))
    else $error("data mask missing on strobe pins");
  a_strobes_own: assert property (@(posedge i_clk) disable iff (i_rst)
    !dqm_str |=> o_row_strobe_second_n == $past(i_row_strobe_second_n)
      && o_column_strobe_second_n == $past(i_column_strobe_second_n)
      && o_write_enable_second_n == $past(i_write_enable_second_n))
    else $error("second strobes not on their own pins");
  a_dqm_arb_pin: assert property (@(posedge i_clk) disable iff (i_rst)
    dqm_arb |=> o_pci64_arbitration_out == $past(i_sdram_data_mask_out))
    else $error("data mask missing on arbiter pin");
  a_arb_pin_own: assert property (@(posedge i_clk) disable iff (i_rst)
    !dqm_arb |=> o_pci64_arbitration_out == $past(i_pci64_arbitration_out))
    else $error("arbiter output not on its own pin");
  a_pci32_status: assert property (@(posedge i_clk) disable iff (i_rst)
    ##1 o_chip_control_word[CSM_BIT_PCI32_EXT] == $past(ext32_r) && o_pci32_arb_enable == !$past(ext32_r))
    else $error("pci32 mode status mismatch");
  a_pci64_status: assert property (@(posedge i_clk) disable iff (i_rst)
    ##1 o_chip_control_word[CSM_BIT_PCI64_EXT] == $past(ext64_r) && o_pci64_arb_enable == !$past(ext64_r))
    else $error("pci64 mode status mismatch");
  a_strap_low_ext: assert property (@(posedge i_clk) disable iff (i_rst)
    capture && !r32_s2_r |=> ext32_r ##2 !o_pci32_arb_enable)
    else $error("low pci32 strap did not disable arbiter");
  a_strap_high_int: assert property (@(posedge i_clk) disable iff (i_rst)
    capture && r32_s2_r |=> !ext32_r ##1 o_pci32_arb_enable)
    else $error("high pci32 strap did not keep arbiter");
  a_strap_low_wide: assert property (@(posedge i_clk) disable iff (i_rst)
    capture && !r64_s2_r |=> ext64_r ##1 !o_pci64_arb_enable)
    else $error("low pci64 strap did not disable arbiter");
  a_wide_high_int: assert property (@(posedge i_clk) disable iff (i_rst)
    capture && r64_s2_r |=> !ext64_r ##1 o_pci64_arb_enable)
    else $error("high pci64 strap did not keep arbiter");
  a_no_late_sample: assert property (@(posedge i_clk) disable iff (i_rst)
    !pll_s2_r |=> $stable(ext32_r) && $stable(ext64_r))
    else $error("strap taken without pll reset");
  a_sample_wait: assert property (@(posedge i_clk) disable iff (i_rst)
    state_r == CSM_SAMPLE && pg_s2_r && !pll_s2_r |=> state_r == CSM_SAMPLE)
    else $error("sampling left without pll reset");
  a_hold_rearm: assert property (@(posedge i_clk) disable iff (i_rst)
    state_r == CSM_HOLD && !pg_s2_r |=> state_r == CSM_WAIT_PG)
    else $error("power loss did not re-arm capture");
  a_strap_held: assert property (@(posedge i_clk) disable iff (i_rst)
    state_r == CSM_HOLD && pg_s2_r |=> $stable(ext32_r) && $stable(ext64_r))
    else $error("strap changed while held");
endmodule // csm_pin_mux
`default_nettype wire

/* bench/csm_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
module csm_far_model
(
  input wire logic i_clk,
  input wire logic i_pll_reset,
  input wire logic i_ext32,
  input wire logic i_ext64,
  output logic o_req32_n,
  output logic o_req64_n
);
  logic tog_r = 1'h0;
  always @(posedge i_clk)
    tog_r <= ~tog_r;
  // low strap means external arbiter; later traffic must be ignored
  assign o_req32_n = i_pll_reset ? ~i_ext32 : tog_r;
  assign o_req64_n = i_pll_reset ? ~i_ext64 : ~tog_r;
endmodule // csm_far_model
`default_nettype wire

/* bench/tb_cs_mux_and_arbiter_strap.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_cs_mux_and_arbiter_strap;
  import csm_pkg::*;
  typedef struct packed {int due; logic [49:0] v;} csm_note_t;
  logic i_clk = 1'h0, i_rst = 1'h1, pg = 1'h0, pll = 1'h1, w32 = 1'h0, w64 = 1'h0;
  logic [CSM_CTL_W-1:0] cfg = '0;
  logic [CSM_CS_OUT_W-1:0] cs = '1;
  logic dm = 1'h0, rs = 1'h1, cas = 1'h1, we = 1'h1, arb = 1'h0, ext32 = 1'h0, ext64 = 1'h0;
  wire r32, r64;
  wire [49:0] got;
  csm_note_t q[$];
  csm_note_t e;
  int cyc = 0, fails = 0, compares = 0;
  integer seed = 50;
  csm_far_model far (.i_clk(i_clk), .i_pll_reset(pll), .i_ext32(w32), .i_ext64(w64),
    .o_req32_n(r32), .o_req64_n(r64));
  csm_pin_mux dut (.i_clk(i_clk), .i_rst(i_rst), .i_memory_controller_config(cfg),
    .i_mem_chip_select_n(cs), .i_sdram_data_mask_out(dm), .i_row_strobe_second_n(rs),
    .i_column_strobe_second_n(cas), .i_write_enable_second_n(we), .i_pci64_arbitration_out(arb),
    .i_power_good_in(pg), .i_pll_reset(pll), .i_pci32_request_two_n(r32), .i_pci64_request_two_n(r64),
    .o_mem_chip_select_n(got[49:38]), .o_row_strobe_second_n(got[37]), .o_column_strobe_second_n(got[36]),
    .o_write_enable_second_n(got[35]), .o_pci64_arbitration_out(got[34]), .o_pci32_arb_enable(got[33]),
    .o_pci64_arb_enable(got[32]), .o_chip_control_word(got[31:0]));
  initial
  begin
    forever #4 i_clk = ~i_clk;
  end
  task automatic print_verdict;
    $display("counts: %0d compares, %0d fails", compares, fails);
    if (fails == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // waits past the edge so the new inputs are visible
  task automatic note;
    logic [49:0] v;
    #1;
    v = {cs, rs, cas, we, arb, ~ext32, ~ext64, CSM_CTL_ZERO};
    if (cfg[CSM_BIT_CS_TO_4_7]) v[45:42] = cs[3:0];
    if (cfg[CSM_BIT_CS_TO_8_11]) v[49:46] = cs[3:0];
    if (cfg[CSM_BIT_DQM_STROBES]) v[37:35] = {3{dm}};
    if (cfg[CSM_BIT_DQM_ARB]) v[34] = dm;
    v[CSM_BIT_PCI32_EXT] = ext32;
    v[CSM_BIT_PCI64_EXT] = ext64;
    q.push_back('{cyc + 1, v});
  endtask
  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    if (cyc > 3000)
    begin
      fails++;
      print_verdict();
    end
  end
  always @(negedge i_clk)
  begin
    if (q.size() != 0 && q[0].due <= cyc)
    begin
      e = q.pop_front();
      compares++;
      if (got !== e.v)
      begin
        fails++;
        $display("wrong value at %0t: got %h exp %h", $time, got, e.v);
      end
    end
  end
  initial
  begin
    repeat (5) @(posedge i_clk);
    i_rst <= 1'h0;
    for (int i = 0; i < 32; i++)
    begin
      @(posedge i_clk);
      cfg <= ($random(seed) & 32'hFFFF07FF) | (32'(i) << 11);
      {cs, dm, rs, cas, we, arb} <= 17'($random(seed));
      note();
    end
    $display("mux test done");
    // power-good falls between runs, so each run re-arms capture
    for (int k = 0; k < 4; k++)
    begin
      @(posedge i_clk);
      pg <= 1'h0;
      pll <= 1'h1;
      {w32, w64} <= 2'(k);
      repeat (6) @(posedge i_clk);
      pg <= 1'h1;
      repeat (12) @(posedge i_clk);
      pll <= 1'h0;
      {ext32, ext64} = 2'(k);
      note();
      repeat (8) @(posedge i_clk);
      note();
    end
    // power good with pll reset inactive: capture must wait for it
    @(posedge i_clk);
    pg <= 1'h0;
    {w32, w64} <= 2'h0;
    repeat (6) @(posedge i_clk);
    pg <= 1'h1;
    repeat (12) @(posedge i_clk);
    note();
    @(posedge i_clk);
    pll <= 1'h1;
    repeat (12) @(posedge i_clk);
    {ext32, ext64} = 2'h0;
    note();
    repeat (4) @(posedge i_clk);
    $display("strap test done");
    print_verdict();
  end
endmodule // tb_cs_mux_and_arbiter_strap
`default_nettype wire
